// File: pkg/lm_map.svh
`ifndef LM_MAP_SVH
`define LM_MAP_SVH

// ----------------------------------------------------------------
// Loop unit constants
// ----------------------------------------------------------------
`define LM_LOOP_DISP  16'hFFFC
`define LM_CNT_DONE   16'hFFFF
`define LM_CNT_STEP   16'h0001
`define LM_WORD_STEP  32'h0000_0002
`define LM_LONG_STEP  32'h0000_0004
`define LM_Q_DEPTH    2
`define LM_RST_WORD   16'h0000
`define LM_RST_ADDR   32'h0000_0000

`endif

// File: pkg/lm_pkg.sv
`default_nettype none

package lm_pkg;
    typedef logic [15:0] lm_word_t;
    typedef logic [31:0] lm_addr_t;
    typedef enum logic [1:0] {LM_IDLE, LM_ARMED, LM_LOOP} lm_state_e;
endpackage

`default_nettype wire

// File: src/lm_qualify.sv
`timescale 1ns/1ps
`default_nettype none

module lm_qualify
(
    input  wire lm_pkg::lm_word_t opcode,
    output logic                  loop_ok
);
    import lm_pkg::*;

    logic [3:0] grp;
    logic [2:0] opm;
    logic [2:0] mode;
    logic [1:0] sz;
    logic       mem_ea;
    logic       move_ok;
    logic       to_dreg;
    logic       to_areg;
    logic       to_mem;
    logic       ext_mem;
    logic       cmp_mem;
    logic       unary;
    logic       shift1;

    assign grp  = opcode[15:12];
    assign opm  = opcode[8:6];
    assign mode = opcode[5:3];
    assign sz   = opcode[7:6];

    // Only the three indirect modes keep the instruction at one word
    assign mem_ea = (mode >= 3'h2) && (mode <= 3'h4);

    assign move_ok = (opcode[15:14] == 2'h0) && (opcode[13:12] != 2'h0)
                   && (opm >= 3'h2) && (opm <= 3'h4)
                   && (mode <= 3'h4);

    assign to_dreg = ((grp == 4'hD) || (grp == 4'hC) || (grp == 4'hB)
                   || (grp == 4'h8) || (grp == 4'h9))
                   && (opm <= 3'h2) && mem_ea;

    assign to_areg = ((grp == 4'hD) || (grp == 4'hB) || (grp == 4'h9))
                   && ((opm == 3'h3) || (opm == 3'h7)) && mem_ea;

    // Group B with these modes is the exclusive_or_op form
    assign to_mem  = ((grp == 4'hD) || (grp == 4'hC) || (grp == 4'hB)
                   || (grp == 4'h8) || (grp == 4'h9))
                   && (opm >= 3'h4) && (opm <= 3'h6) && mem_ea;

    assign ext_mem = (((grp == 4'hD) || (grp == 4'h9)) && opcode[8]
                   && (sz != 2'h3) && (mode == 3'h1))
                   || (((grp == 4'hC) || (grp == 4'h8)) && (opm == 3'h4)
                   && (mode == 3'h1));

    assign cmp_mem = (grp == 4'hB) && opcode[8] && (sz != 2'h3)
                   && (mode == 3'h1);

    assign unary = (((opcode[15:8] == 8'h40) || (opcode[15:8] == 8'h42)
                 || (opcode[15:8] == 8'h44) || (opcode[15:8] == 8'h46)
                 || (opcode[15:8] == 8'h4A)) && (sz != 2'h3) && mem_ea)
                 || ((opcode[15:6] == 10'h120) && mem_ea);

    // Memory shift forms always shift by exactly one
    assign shift1 = (grp == 4'hE) && !opcode[11] && (sz == 2'h3)
                  && mem_ea;

    assign loop_ok = move_ok || to_dreg || to_areg || to_mem
                   || ext_mem || cmp_mem || unary || shift1;

endmodule

`default_nettype wire

// File: src/lm_loop_ctrl.sv
// How it works
// - Branch step decrements low counter half by one, compares with minus one.
// - Count reaching minus one is written back; execution falls through.
// - Otherwise a true condition discards the count and falls through.
// - Count live and condition false: branch to pc plus two plus displacement.
// - Two-word queue plus decode word hold the loop pair in loop mode.
// - Enter silently only for looping, displacement minus four, qualifying word.
// - Loop words fetched twice; second decode of qualifier starts loop mode.
// - In loop mode only operand bus cycles run, no opcode fetches.
// - Interrupts sampled only after branch steps while looping.
// - Any taken exception ends loop mode; later re-entry stays possible.
// - Trace set traps after both instructions, so loop never starts.
// - Reset clears all loop state.
// - Bus error handled normally; resume restores loop without refetch.
// - Only one-word encodings with indirect memory operands qualify.
// - Moves qualify with register or indirect source, indirect destination.
// - Listed two-operand arithmetic and logic forms qualify.
// - Single-operand forms qualify with indirect memory operands.
// - Word memory shifts and rotates qualify only by a count of one.
`timescale 1ns/1ps
`default_nettype none
`include "lm_map.svh"

module lm_loop_ctrl
(
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    output logic                  fetch_req,
    output lm_pkg::lm_addr_t      fetch_addr,
    input  wire logic             fetch_ack,
    input  wire lm_pkg::lm_word_t fetch_data,
    input  wire logic             ird_advance,
    output lm_pkg::lm_word_t      ird,
    output logic                  ird_valid,
    output lm_pkg::lm_addr_t      ird_pc,
    output lm_pkg::lm_word_t      q_word0,
    output lm_pkg::lm_word_t      q_word1,
    output logic [1:0]            q_valid,
    input  wire logic             instr_done,
    input  wire logic             test_decrement_branch_exec,
    input  wire lm_pkg::lm_addr_t test_decrement_branch_pc,
    input  wire lm_pkg::lm_word_t test_decrement_branch_count,
    input  wire logic             test_decrement_branch_cond,
    input  wire lm_pkg::lm_word_t test_decrement_branch_disp,
    output logic                  cnt_we,
    output lm_pkg::lm_word_t      cnt_wdata,
    output logic                  branch_taken,
    output lm_pkg::lm_addr_t      branch_pc,
    output logic                  irq_window,
    input  wire logic             trace_en,
    output logic                  trace_take,
    input  wire logic             exc_take,
    input  wire logic             berr,
    input  wire lm_pkg::lm_addr_t exc_pc,
    input  wire logic             rte_resume,
    output logic                  loop_active
);
    import lm_pkg::*;

    localparam int DEPTH = `LM_Q_DEPTH;

    lm_state_e state;
    lm_word_t  q      [DEPTH];
    logic      qv     [DEPTH];
    lm_word_t  sh_q   [DEPTH];
    lm_word_t  sh_ird;
    lm_addr_t  sh_pc;
    logic      sh_v;
    lm_addr_t  loop_pc;
    lm_addr_t  exec_pc;
    lm_addr_t  prev_pc;
    logic      exec_ok;
    logic      prev_ok;
    logic      ird_ok;
    logic      test_decrement_branch_done;
    lm_word_t  dec;
    logic      expired;
    logic      looping;
    lm_addr_t  target;
    lm_addr_t  fall_pc;
    logic      entry_ok;
    logic      exc;
    logic      restore;
    logic      redirect;
    lm_addr_t  redir_pc;
    logic      q_full;
    logic      ird_load;
    logic      push;
    logic [1:0] qcnt;
    logic [1:0] wpos;

    // ----------------------------------------------------------------
    // Branch step arithmetic
    // ----------------------------------------------------------------
    assign dec      = test_decrement_branch_count - `LM_CNT_STEP;
    assign expired  = (dec == `LM_CNT_DONE);
    assign looping  = !expired && !test_decrement_branch_cond;
    assign target   = test_decrement_branch_pc + `LM_WORD_STEP
                    + {{16{test_decrement_branch_disp[15]}}, test_decrement_branch_disp};
    assign fall_pc  = test_decrement_branch_pc + `LM_LONG_STEP;
    // The previous word must sit right before the branch: one word only
    assign entry_ok = looping && (test_decrement_branch_disp == `LM_LOOP_DISP) && prev_ok
                    && (prev_pc == test_decrement_branch_pc - `LM_WORD_STEP)
                    && !trace_en;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_we       <= 1'b0;
            cnt_wdata    <= `LM_RST_WORD;
            branch_taken <= 1'b0;
            branch_pc    <= `LM_RST_ADDR;
            test_decrement_branch_done    <= 1'b0;
        end
        else
        begin
            // Count is kept on exhaustion and on looping, dropped if cond
            cnt_we       <= test_decrement_branch_exec && (expired || looping);
            branch_taken <= test_decrement_branch_exec && looping;
            test_decrement_branch_done    <= test_decrement_branch_exec;
            if (test_decrement_branch_exec)
            begin
                cnt_wdata <= dec;
                branch_pc <= looping ? target : fall_pc;
            end
        end
    end

    // ----------------------------------------------------------------
    // Flow control and exceptions
    // ----------------------------------------------------------------
    assign exc     = exc_take || berr;
    assign restore = rte_resume && sh_v && !exc;

    always_comb
    begin
        redirect = 1'b0;
        redir_pc = exc_pc;
        if (exc || (rte_resume && !sh_v))
        begin
            redirect = 1'b1;
        end
        else if (test_decrement_branch_exec && looping && (state != LM_LOOP))
        begin
            redirect = 1'b1;
            redir_pc = target;
        end
        else if (test_decrement_branch_exec && !looping && (state == LM_LOOP))
        begin
            redirect = 1'b1;
            redir_pc = fall_pc;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state   <= LM_IDLE;
            loop_pc <= `LM_RST_ADDR;
        end
        else if (exc)
        begin
            state <= LM_IDLE;
        end
        else if (restore)
        begin
            state <= LM_LOOP;
        end
        else
        begin
            case (state)
                LM_IDLE:
                begin
                    if (test_decrement_branch_exec && entry_ok)
                    begin
                        state   <= LM_ARMED;
                        loop_pc <= prev_pc;
                    end
                end
                LM_ARMED:
                begin
                    // Second fetch of the looped word with the pair queued
                    if (redirect || test_decrement_branch_exec || trace_en)
                        state <= LM_IDLE;
                    else if (ird_valid && ird_ok && (ird_pc == loop_pc)
                             && q_full)
                        state <= LM_LOOP;
                end
                LM_LOOP:
                begin
                    if (test_decrement_branch_exec && !looping)
                        state <= LM_IDLE;
                end
                default: state <= LM_IDLE;
            endcase
        end
    end

    assign loop_active = (state == LM_LOOP);
    // Looped instruction never opens the interrupt window
    assign irq_window  = !loop_active || test_decrement_branch_done;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            trace_take <= 1'b0;
        else
            trace_take <= trace_en && (instr_done || test_decrement_branch_exec);
    end

    // ----------------------------------------------------------------
    // Prefetch queue and decode word
    // ----------------------------------------------------------------
    assign q_full   = qv[0] && qv[1];
    assign fetch_req = !loop_active && !q_full;
    assign push     = fetch_req && fetch_ack && !redirect;
    // Decode word and queue freeze while looping
    assign ird_load = qv[0] && (!ird_valid || ird_advance)
                    && !loop_active && !redirect;
    assign qcnt     = {1'b0, qv[0]} + {1'b0, qv[1]};
    assign wpos     = qcnt - {1'b0, ird_load};
    assign q_word0  = q[0];
    assign q_word1  = q[1];
    assign q_valid  = {qv[1], qv[0]};

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_q
            lm_word_t up_d;
            logic     up_v;
            if (gi + 1 < DEPTH)
            begin : g_mid
                assign up_d = q[gi+1];
                assign up_v = qv[gi+1];
            end
            else
            begin : g_top
                assign up_d = `LM_RST_WORD;
                assign up_v = 1'b0;
            end

            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    q[gi]  <= `LM_RST_WORD;
                    qv[gi] <= 1'b0;
                end
                else if (restore)
                begin
                    q[gi]  <= sh_q[gi];
                    qv[gi] <= 1'b1;
                end
                else if (redirect)
                    qv[gi] <= 1'b0;
                else if (push && (wpos == 2'(gi)))
                begin
                    q[gi]  <= fetch_data;
                    qv[gi] <= 1'b1;
                end
                else if (ird_load)
                begin
                    q[gi]  <= up_d;
                    qv[gi] <= up_v;
                end
            end

            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                    sh_q[gi] <= `LM_RST_WORD;
                else if (berr && loop_active)
                    sh_q[gi] <= q[gi];
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ird       <= `LM_RST_WORD;
            ird_valid <= 1'b0;
            // First load steps onto the reset address
            ird_pc    <= `LM_RST_ADDR - `LM_WORD_STEP;
        end
        else if (restore)
        begin
            ird       <= sh_ird;
            ird_valid <= 1'b1;
            ird_pc    <= sh_pc;
        end
        else if (redirect)
        begin
            // Next load from the queue lands on the new address
            ird_valid <= 1'b0;
            ird_pc    <= redir_pc - `LM_WORD_STEP;
        end
        else if (ird_load)
        begin
            ird       <= q[0];
            ird_valid <= 1'b1;
            ird_pc    <= ird_pc + `LM_WORD_STEP;
        end
        else if (ird_advance && !loop_active)
            ird_valid <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            fetch_addr <= `LM_RST_ADDR;
        else if (restore)
            fetch_addr <= sh_pc + `LM_WORD_STEP + `LM_LONG_STEP;
        else if (redirect)
            fetch_addr <= redir_pc;
        else if (push)
            fetch_addr <= fetch_addr + `LM_WORD_STEP;
    end

    // Bus error keeps the three-word loop so the resume needs no fetch
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sh_v   <= 1'b0;
            sh_ird <= `LM_RST_WORD;
            sh_pc  <= `LM_RST_ADDR;
        end
        else if (berr && loop_active)
        begin
            sh_v   <= 1'b1;
            sh_ird <= ird;
            sh_pc  <= ird_pc;
        end
        else if (restore)
            sh_v <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Candidate tracking
    // ----------------------------------------------------------------
    lm_qualify u_qual
    (
        .opcode  (ird),
        .loop_ok (ird_ok)
    );

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            exec_ok <= 1'b0;
            prev_ok <= 1'b0;
            exec_pc <= `LM_RST_ADDR;
            prev_pc <= `LM_RST_ADDR;
        end
        else if (ird_advance && ird_valid && !loop_active)
        begin
            prev_ok <= exec_ok;
            exec_ok <= ird_ok;
            prev_pc <= exec_pc;
            exec_pc <= ird_pc;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_count_decrement: assert property (
        test_decrement_branch_exec |=> cnt_wdata == $past(test_decrement_branch_count) - `LM_CNT_STEP)
        else $error("count not decremented by one");
    a_expired_write: assert property (
        test_decrement_branch_exec && expired |=> cnt_we && !branch_taken
                                 && branch_pc == $past(fall_pc))
        else $error("exhausted count not written back");
    a_cond_discard: assert property (
        test_decrement_branch_exec && !expired && test_decrement_branch_cond |=> !cnt_we && !branch_taken)
        else $error("true condition did not discard count");
    a_branch_target: assert property (
        test_decrement_branch_exec && looping |=> branch_taken
                                 && branch_pc == $past(target))
        else $error("branch target wrong");
    a_no_loop_fetch: assert property (
        loop_active |-> !fetch_req)
        else $error("opcode fetch while looping");
    a_irq_branch_only: assert property (
        loop_active && !$past(test_decrement_branch_exec) |-> !irq_window)
        else $error("interrupt window after looped instruction");
    a_exc_exits: assert property (
        exc |=> !loop_active ##1 fetch_req || q_full)
        else $error("exception did not end loop mode");
    a_trace_blocks: assert property (
        trace_en && instr_done |=> trace_take && !$rose(loop_active))
        else $error("trace not raised or loop entered");
    a_resume_loop: assert property (
        restore |=> loop_active && !fetch_req && ird_pc == $past(sh_pc))
        else $error("resume refetched the loop");
    a_exit_refetch: assert property (
        loop_active && test_decrement_branch_exec && !looping
        |=> !loop_active && fetch_addr == $past(fall_pc))
        else $error("loop exit resumed at wrong address");

    c_loop_entered: cover property ($rose(loop_active));
    c_loop_counted: cover property (loop_active && test_decrement_branch_exec && expired);
    c_loop_resumed: cover property (restore);

endmodule

`default_nettype wire

// File: tb/lm_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module lm_mem_model
(
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    input  wire lm_pkg::lm_addr_t fetch_addr,
    input  wire logic             slow,
    input  wire lm_pkg::lm_word_t loop_word,
    output logic                  fetch_ack,
    output lm_pkg::lm_word_t      fetch_data
);
    import lm_pkg::*;
    lm_word_t word;

    // ------------------------------------------------------------
    // Program image
    // ------------------------------------------------------------
    // Looped word from the bench, then the branch pair; filler elsewhere
    always_comb
    begin
        case (fetch_addr)
            32'h0000_0000: word = loop_word;
            32'h0000_0002: word = 16'h51C8;
            32'h0000_0004: word = 16'hFFFC;
            default:       word = 16'h4E71;
        endcase
    end

    // ------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------
    // Ack runs free; the core ignores it while it is not requesting
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            fetch_ack <= 1'b0;
        else
            fetch_ack <= !slow || !fetch_ack;
    end

    // Outside an ack the data bus carries nothing usable
    assign fetch_data = fetch_ack ? word : ~word;
endmodule

`default_nettype wire

// File: tb/single_instruction_loop_mode_test.sv
`timescale 1ns/1ps
`default_nettype none

module single_instruction_loop_mode_test;
    import lm_pkg::*;
    logic       core_clk, arst_n, fetch_req, fetch_ack, ird_advance, ird_valid;
    logic       instr_done, test_decrement_branch_exec, test_decrement_branch_cond, cnt_we, branch_taken;
    logic       irq_window, trace_en, trace_take, exc_take, berr, rte_resume;
    logic       loop_active, slow, in_loop;
    logic [1:0] q_valid;
    lm_word_t   fetch_data, ird, q_word0, q_word1, test_decrement_branch_count, test_decrement_branch_disp;
    lm_word_t   cnt_wdata, opcode, cnt;
    lm_addr_t   fetch_addr, ird_pc, test_decrement_branch_pc, branch_pc, exc_pc;
    int         error_cnt, compares, cycles, seed, loop_fetches;
    logic [16:0] qual_ops [8] = '{17'h1_32D8, 17'h1_2290, 17'h0_3010,
        17'h0_3028, 17'h1_D150, 17'h1_4258, 17'h1_E0D0, 17'h0_4E71};

    lm_loop_ctrl dut
    (
        .core_clk(core_clk), .arst_n(arst_n), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
        .fetch_data(fetch_data), .ird_advance(ird_advance), .ird(ird),
        .ird_valid(ird_valid), .ird_pc(ird_pc), .q_word0(q_word0),
        .q_word1(q_word1), .q_valid(q_valid), .instr_done(instr_done),
        .test_decrement_branch_exec(test_decrement_branch_exec), .test_decrement_branch_pc(test_decrement_branch_pc), .test_decrement_branch_count(test_decrement_branch_count),
        .test_decrement_branch_cond(test_decrement_branch_cond), .test_decrement_branch_disp(test_decrement_branch_disp), .cnt_we(cnt_we),
        .cnt_wdata(cnt_wdata), .branch_taken(branch_taken),
        .branch_pc(branch_pc), .irq_window(irq_window),
        .trace_en(trace_en), .trace_take(trace_take), .exc_take(exc_take),
        .berr(berr), .exc_pc(exc_pc), .rte_resume(rte_resume),
        .loop_active(loop_active)
    );
    lm_mem_model mem
    (
        .core_clk(core_clk), .arst_n(arst_n), .fetch_addr(fetch_addr),
        .slow(slow), .loop_word(opcode), .fetch_ack(fetch_ack),
        .fetch_data(fetch_data)
    );

    // ------------------------------------------------------------
    // Clock, watchdog, loop fetch monitor
    // ------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (loop_active === 1'b1 && fetch_req === 1'b1 && fetch_ack)
            loop_fetches++;
        if (cycles == 5000)
        begin
            error_cnt++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk_addr(input lm_addr_t got, input lm_addr_t exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input lm_word_t got, input lm_word_t exp);
        chk_addr({16'h0000, got}, {16'h0000, exp});
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_addr({31'h0, got}, {31'h0, exp});
    endtask

    task automatic conclude();
        if (error_cnt == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    task automatic do_reset();
        arst_n = 1'b0;
        tick();
        chk_bit(loop_active, 1'b0);
        chk_bit(fetch_req, 1'b1);
        chk_bit(cnt_we, 1'b0);
        arst_n = 1'b1;
        tick();
    endtask

    task automatic pulse_done();
        instr_done = 1'b1;
        tick();
        instr_done = 1'b0;
        if (in_loop)
            chk_bit(irq_window, 1'b0);
        if (trace_en)
            chk_bit(trace_take, 1'b1);
    endtask

    // Counter step of the loop-closing branch: what the core must see
    function automatic void exp_step(input lm_word_t c, input logic cond,
        input lm_word_t disp, input lm_addr_t pc, output logic we,
        output logic tk, output lm_word_t wd, output lm_addr_t npc);
        wd = c - 16'h0001;
        tk = (wd != 16'hFFFF) && !cond;
        we = (wd == 16'hFFFF) || tk;
        npc = tk ? pc + 32'h2 + {{16{disp[15]}}, disp} : pc + 32'h4;
    endfunction

    task automatic step(input lm_word_t c, input logic cond,
        input lm_word_t disp, input lm_addr_t pc);
        logic     we;
        logic     tk;
        lm_word_t wd;
        lm_addr_t npc;
        exp_step(c, cond, disp, pc, we, tk, wd, npc);
        {test_decrement_branch_count, test_decrement_branch_cond, test_decrement_branch_disp, test_decrement_branch_pc} = {c, cond, disp, pc};
        test_decrement_branch_exec = 1'b1;
        tick();
        test_decrement_branch_exec = 1'b0;
        chk_bit(cnt_we, we);
        if (we)
            chk_word(cnt_wdata, wd);
        chk_bit(branch_taken, tk);
        chk_addr(branch_pc, npc);
        if (tk && !in_loop && loop_active !== 1'b1)
            chk_addr(fetch_addr, npc);
        if (in_loop)
            chk_bit(irq_window, 1'b1);
        if (trace_en)
            chk_bit(trace_take, 1'b1);
    endtask

    // Core walks the loop pair once; entry must follow the refetch
    task automatic enter(input logic want);
        int n;
        n = 0;
        while (!(ird === opcode && q_valid === 2'b11) && n < 50)
        begin
            tick();
            n++;
        end
        pulse_done();
        // Looped word, then the branch word, leave the decode register
        ird_advance = 1'b1;
        repeat (2) tick();
        ird_advance = 1'b0;
        step(16'h0005, 1'b0, 16'hFFFC, 32'h2);
        n = 0;
        while (loop_active !== 1'b1 && n < 20)
        begin
            tick();
            n++;
        end
        chk_bit(loop_active, want);
    endtask

    task automatic exc_pulse(input logic fault, input lm_addr_t pc);
        exc_pc = pc;
        berr = fault;
        exc_take = !fault;
        tick();
        {berr, exc_take} = 2'b00;
        chk_bit(loop_active, 1'b0);
        chk_addr(fetch_addr, pc);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 89888;
        {error_cnt, compares, cycles, loop_fetches} = '0;
        {ird_advance, instr_done, test_decrement_branch_exec, test_decrement_branch_cond, trace_en} = '0;
        {exc_take, berr, rte_resume, slow, in_loop} = '0;
        {test_decrement_branch_count, test_decrement_branch_disp} = '0;
        opcode = 16'h32D8;
        {test_decrement_branch_pc, exc_pc} = '0;
        arst_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        do_reset();
        for (int i = 0; i < 40; i++)
        begin
            slow = 1'($random(seed));
            cnt = (i % 3 == 2) ? 16'($random(seed)) : 16'(i % 3);
            step(cnt, 1'($random(seed)), 16'($random(seed)) & 16'hFFF0,
                32'h1000 | (32'($random(seed)) & 32'h0FFE));
        end
        do_reset();
        enter(1'b1);
        chk_word(ird, 16'h32D8);
        chk_word(q_word0, 16'h51C8);
        chk_word(q_word1, 16'hFFFC);
        in_loop = 1'b1;
        for (int k = 4; k > 1; k--)
        begin
            pulse_done();
            step(16'(k), 1'b0, 16'hFFFC, 32'h2);
            chk_bit(fetch_req, 1'b0);
        end
        in_loop = 1'b0;
        pulse_done();
        step(16'h0000, 1'b0, 16'hFFFC, 32'h2);
        chk_bit(loop_active, 1'b0);
        chk_addr(fetch_addr, 32'h6);
        slow = 1'b1;
        exc_pulse(1'b0, 32'h0);
        enter(1'b1);
        pulse_done();
        step(16'h0005, 1'b1, 16'hFFFC, 32'h2);
        chk_bit(loop_active, 1'b0);
        exc_pulse(1'b0, 32'h0);
        enter(1'b1);
        exc_pulse(1'b0, 32'h0);
        enter(1'b1);
        exc_pulse(1'b1, 32'h40);
        repeat (6) tick();
        rte_resume = 1'b1;
        tick();
        rte_resume = 1'b0;
        chk_bit(loop_active, 1'b1);
        chk_word(ird, 16'h32D8);
        chk_bit(fetch_req, 1'b0);
        do_reset();
        trace_en = 1'b1;
        enter(1'b0);
        trace_en = 1'b0;
        chk_addr(32'(loop_fetches), 32'h0);
        // Each candidate sits in the looped slot; entry shows if it qualifies
        foreach (qual_ops[j])
        begin
            opcode = qual_ops[j][15:0];
            exc_pulse(1'b0, 32'h0);
            enter(qual_ops[j][16]);
        end
        conclude();
    end
endmodule

`default_nettype wire
